// ===== pfc_pin_control.sv
/*
 * Control, filtering and function routing of one general-purpose pin
 * with an AXI4-Lite register slave and a level interrupt.
 * Assumes the pad input is synchronous to aclk and that the pad ring
 * resolves pin_out and pin_oe into the wire level.
 */
// Contract
// - Pull field bits 14:13, 00 none, 01 down, 10 up, 11 reserved; reset 01.
// - Mode bit 12 low: interrupt on rising edge if polarity 1, else falling.
// - Mode bit 12 high: interrupt on both edges; mode resets to 0.
// - Bit 11 selects pin supply: 0 I/O buffer, 1 internal always-on.
// - Polarity bit 10: 0 inverts (active low), 1 non-inverted; reset 1.
// - Bit 9 selects driver: 0 push-pull, 1 open-drain pulling low only.
// - Bit 7 low tri-states pin, high normal operation; resets low.
// - Function bits 3:0 per direction bit 15; input 0 long-filtered, 1 plain.
// - Input codes 2-6 give on/off, sleep/wake, long sleep/wake, sleep, power-on.
// - Input code 7 watchdog reset; codes 8, 9 voltage scaling selects.
// - Input 10-11 hardware enables, 12-13 controls, 14-15 long-filtered controls.
// - Output code 0 register level, code 1 the 32.768kHz oscillator.
// - Output codes 2-4 on, sleep, state change; codes 5-7 reserved.
// - Output 8-9 converter scaling done, 10-11 external power enables.
// - Output code 12 system supply good, 13 converter power good.
// - Output code 14 the 2MHz power clock, 15 auxiliary reset.
`timescale 1ns/1ps

module pfc_pin_control #(
  parameter int DEB_SHORT = pfc_pkg::DEB_SHORT_CYC,
  parameter int DEB_LONG = pfc_pkg::DEB_LONG_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [pfc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pfc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic pull_up_en,
  output logic pull_down_en,
  output logic io_supply_domain_select,
  input wire logic osc_32k_clk,
  input wire logic on_state,
  input wire logic sleep_state,
  input wire logic power_state_change,
  input wire logic dcdc1_scaling_done,
  input wire logic dcdc2_scaling_done,
  input wire logic ext_power_en1,
  input wire logic ext_power_en2,
  input wire logic system_supply_good,
  input wire logic converter_power_good,
  input wire logic ext_power_clk_2m,
  input wire logic aux_reset,
  output logic power_onoff_req,
  output logic sleep_wake_req,
  output logic sleep_wake_long_req,
  output logic sleep_req,
  output logic power_on_req,
  output logic watchdog_reset_in,
  output logic voltage_scaling_select_one,
  output logic voltage_scaling_select_two,
  output logic hw_enable1,
  output logic hw_enable2,
  output logic hw_control1,
  output logic hw_control2,
  output logic hw_control1_long,
  output logic hw_control2_long,
  output logic irq
);

  logic [15:0] control_r;
  logic [1:0] status_r;
  logic [1:0] mask_r;
  logic level_out_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [pfc_pkg::IDX_W-1:0] aw_idx_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic [1:0] filt_r;
  logic sel_r;
  logic [15:2] route_r;
  logic pin_out_r;
  logic pin_oe_r;
  logic pull_up_r;
  logic pull_down_r;
  logic domain_r;
  logic irq_r;
  logic logic_in;
  logic commit;
  logic edge_evt;
  logic sel_nxt;
  logic drive_level;
  logic [3:0] fn;
  logic dir_in;
  logic pol;
  logic [15:0] ctl_nxt;

  assign fn = control_r[pfc_pkg::FN_HI:pfc_pkg::FN_LO];
  assign dir_in = control_r[pfc_pkg::DIR_BIT];
  assign pol = control_r[pfc_pkg::POL_BIT];
  // Pad level mapped to the logical level
  assign logic_in = pin_in ^ ~pol;
  assign commit = aw_hold_r & w_hold_r & ~bvalid_r;

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      aw_hold_r <= 1'b0;
      aw_idx_r <= '0;
    end else if (s_axi_awvalid && awready_r) begin
      awready_r <= 1'b0;
      aw_hold_r <= 1'b1;
      aw_idx_r <= s_axi_awaddr[pfc_pkg::ADDR_W-1:2];
    end else if (commit) begin
      aw_hold_r <= 1'b0;
    end else if (!aw_hold_r && !bvalid_r) begin
      awready_r <= 1'b1;
    end
  end

  // Write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_r <= 1'b0;
      w_hold_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (s_axi_wvalid && wready_r) begin
      wready_r <= 1'b0;
      w_hold_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (commit) begin
      w_hold_r <= 1'b0;
    end else if (!w_hold_r && !bvalid_r) begin
      wready_r <= 1'b1;
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= pfc_pkg::RESP_OKAY;
    end else if (commit) begin
      bvalid_r <= 1'b1;
      unique case (aw_idx_r)
        pfc_pkg::IDX_CONTROL, pfc_pkg::IDX_STATUS,
        pfc_pkg::IDX_MASK, pfc_pkg::IDX_LEVEL:
          bresp_r <= pfc_pkg::RESP_OKAY;
        default: bresp_r <= pfc_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bready && bvalid_r) begin
      bvalid_r <= 1'b0;
    end
  end

  // Byte-lane merge into the control register
  always_comb begin
    ctl_nxt = control_r;
    if (wstrb_r[0]) begin
      ctl_nxt[7:0] = wdata_r[7:0];
    end
    if (wstrb_r[1]) begin
      ctl_nxt[15:8] = wdata_r[15:8];
    end
    ctl_nxt = ctl_nxt & pfc_pkg::CONTROL_WMASK;
  end

  // Control register; reset gives pull-down, input, polarity high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_r <= pfc_pkg::CONTROL_RESET;
    end else if (commit && aw_idx_r == pfc_pkg::IDX_CONTROL) begin
      control_r <= ctl_nxt;
    end
  end

  // Mask and output level registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= '0;
      level_out_r <= 1'b0;
    end else if (commit && wstrb_r[0]) begin
      if (aw_idx_r == pfc_pkg::IDX_MASK) begin
        mask_r <= wdata_r[1:0];
      end
      if (aw_idx_r == pfc_pkg::IDX_LEVEL) begin
        level_out_r <= wdata_r[pfc_pkg::LEVEL_OUT_BIT];
      end
    end
  end

  // Sticky status, write one to clear, a new event wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (i == pfc_pkg::EVT_EDGE_BIT && edge_evt) begin
          status_r[i] <= 1'b1;
        end else if (commit && wstrb_r[0] &&
                     aw_idx_r == pfc_pkg::IDX_STATUS && wdata_r[i]) begin
          status_r[i] <= 1'b0;
        end
      end
    end
  end

  // Interrupt level from unmasked status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_r & mask_r);
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= pfc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= '0;
      rresp_r <= pfc_pkg::RESP_OKAY;
      unique case (s_axi_araddr[pfc_pkg::ADDR_W-1:2])
        pfc_pkg::IDX_CONTROL: rdata_r[15:0] <= control_r;
        pfc_pkg::IDX_STATUS: rdata_r[1:0] <= status_r;
        pfc_pkg::IDX_MASK: rdata_r[1:0] <= mask_r;
        pfc_pkg::IDX_LEVEL: begin
          rdata_r[pfc_pkg::LEVEL_OUT_BIT] <= level_out_r;
          rdata_r[pfc_pkg::LEVEL_IN_BIT] <= sel_r;
        end
        default: rresp_r <= pfc_pkg::RESP_SLVERR;
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end else if (!rvalid_r) begin
      arready_r <= 1'b1;
    end
  end

  // Normal and long input filters
  generate
    for (genvar g = 0; g < 2; g++) begin : g_filt
      localparam int LEN = (g == 0) ? DEB_SHORT : DEB_LONG;
      logic [31:0] cnt_r;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cnt_r <= '0;
          filt_r[g] <= 1'b0;
        end else if (logic_in == filt_r[g]) begin
          cnt_r <= '0;
        end else if (cnt_r >= 32'(LEN - 1)) begin
          cnt_r <= '0;
          filt_r[g] <= logic_in;
        end else begin
          cnt_r <= cnt_r + 32'h1;
        end
      end
    end
  endgenerate

  // Filter chosen by the input function code
  assign sel_nxt = pfc_pkg::LONG_DEB_CODES[fn] ? filt_r[1] : filt_r[0];

  // Edge per interrupt mode; polarity folds into the logical level
  assign edge_evt = dir_in && (sel_nxt != sel_r) &&
    (control_r[pfc_pkg::INT_MODE_BIT] || sel_nxt);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_r <= 1'b0;
    end else begin
      sel_r <= sel_nxt;
    end
  end

  // Input routing, one output per function code 2 to 15
  generate
    for (genvar c = 2; c < 16; c++) begin : g_route
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          route_r[c] <= 1'b0;
        end else begin
          route_r[c] <= dir_in && fn == 4'(c) && sel_nxt;
        end
      end
    end
  endgenerate

  assign power_onoff_req = route_r[2];
  assign sleep_wake_req = route_r[3];
  assign sleep_wake_long_req = route_r[4];
  assign sleep_req = route_r[5];
  assign power_on_req = route_r[6];
  assign watchdog_reset_in = route_r[7];
  assign voltage_scaling_select_one = route_r[8];
  assign voltage_scaling_select_two = route_r[9];
  assign hw_enable1 = route_r[10];
  assign hw_enable2 = route_r[11];
  assign hw_control1 = route_r[12];
  assign hw_control2 = route_r[13];
  assign hw_control1_long = route_r[14];
  assign hw_control2_long = route_r[15];

  // Output source selection; reserved codes drive inactive
  always_comb begin
    unique case (fn)
      pfc_pkg::OFN_LEVEL: drive_level = level_out_r;
      pfc_pkg::OFN_OSC32K: drive_level = osc_32k_clk;
      pfc_pkg::OFN_ON: drive_level = on_state;
      pfc_pkg::OFN_SLEEP: drive_level = sleep_state;
      pfc_pkg::OFN_CHANGE: drive_level = power_state_change;
      pfc_pkg::OFN_VOLTAGE_SCALING_SELECT_ONE_DONE: drive_level = dcdc1_scaling_done;
      pfc_pkg::OFN_VOLTAGE_SCALING_SELECT_TWO_DONE: drive_level = dcdc2_scaling_done;
      pfc_pkg::OFN_EXT_EN1: drive_level = ext_power_en1;
      pfc_pkg::OFN_EXT_EN2: drive_level = ext_power_en2;
      pfc_pkg::OFN_SYS_GOOD: drive_level = system_supply_good;
      pfc_pkg::OFN_CONV_GOOD: drive_level = converter_power_good;
      pfc_pkg::OFN_CLK2M: drive_level = ext_power_clk_2m;
      pfc_pkg::OFN_AUX_RST: drive_level = aux_reset;
      default: drive_level = 1'b0;
    endcase
  end

  // Pad driver: polarity, tri-state, push-pull or open drain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out_r <= 1'b0;
      pin_oe_r <= 1'b0;
    end else if (dir_in || !control_r[pfc_pkg::ENA_BIT]) begin
      pin_out_r <= 1'b0;
      pin_oe_r <= 1'b0;
    end else if (control_r[pfc_pkg::OD_BIT]) begin
      pin_out_r <= 1'b0;
      pin_oe_r <= ~(drive_level ^ ~pol);
    end else begin
      pin_out_r <= drive_level ^ ~pol;
      pin_oe_r <= 1'b1;
    end
  end

  // Pull resistors and supply domain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pull_up_r <= 1'b0;
      pull_down_r <= 1'b0;
      domain_r <= 1'b0;
    end else begin
      pull_up_r <= control_r[pfc_pkg::PULL_HI:pfc_pkg::PULL_LO] ==
                   pfc_pkg::PULL_UP;
      pull_down_r <= control_r[pfc_pkg::PULL_HI:pfc_pkg::PULL_LO] ==
                     pfc_pkg::PULL_DOWN;
      domain_r <= control_r[pfc_pkg::DOMAIN_BIT];
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign pin_out = pin_out_r;
  assign pin_oe = pin_oe_r;
  assign pull_up_en = pull_up_r;
  assign pull_down_en = pull_down_r;
  assign io_supply_domain_select = domain_r;
  assign irq = irq_r;

endmodule // pfc_pin_control

// ===== pfc_pkg.sv
/*
 * Shared constants for the pin function control block: register
 * indices, field positions, reset values and function codes.
 * Assumes an AXI4-Lite register bus with 32-bit data words.
 */
package pfc_pkg;

  // Bus widths
  localparam int ADDR_W = 18;
  localparam int IDX_W = 16;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CONTROL = 16'h403A;
  localparam logic [IDX_W-1:0] IDX_STATUS = 16'h4100;
  localparam logic [IDX_W-1:0] IDX_MASK = 16'h4101;
  localparam logic [IDX_W-1:0] IDX_LEVEL = 16'h4102;

  // Control register fields
  localparam int DIR_BIT = 15;
  localparam int PULL_HI = 14;
  localparam int PULL_LO = 13;
  localparam int INT_MODE_BIT = 12;
  localparam int DOMAIN_BIT = 11;
  localparam int POL_BIT = 10;
  localparam int OD_BIT = 9;
  localparam int ENA_BIT = 7;
  localparam int FN_HI = 3;
  localparam int FN_LO = 0;

  // Control reset value and writable bits
  localparam logic [15:0] CONTROL_RESET = 16'hA400;
  localparam logic [15:0] CONTROL_WMASK = 16'hFE8F;

  // Pull field encodings
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP = 2'h2;

  // Level register fields
  localparam int LEVEL_OUT_BIT = 0;
  localparam int LEVEL_IN_BIT = 1;

  // Status and mask fields
  localparam int EVT_EDGE_BIT = 0;

  // Input function codes that use the long filter
  localparam logic [15:0] LONG_DEB_CODES = 16'hC011;

  // Output function codes
  localparam logic [3:0] OFN_LEVEL = 4'h0;
  localparam logic [3:0] OFN_OSC32K = 4'h1;
  localparam logic [3:0] OFN_ON = 4'h2;
  localparam logic [3:0] OFN_SLEEP = 4'h3;
  localparam logic [3:0] OFN_CHANGE = 4'h4;
  localparam logic [3:0] OFN_VOLTAGE_SCALING_SELECT_ONE_DONE = 4'h8;
  localparam logic [3:0] OFN_VOLTAGE_SCALING_SELECT_TWO_DONE = 4'h9;
  localparam logic [3:0] OFN_EXT_EN1 = 4'hA;
  localparam logic [3:0] OFN_EXT_EN2 = 4'hB;
  localparam logic [3:0] OFN_SYS_GOOD = 4'hC;
  localparam logic [3:0] OFN_CONV_GOOD = 4'hD;
  localparam logic [3:0] OFN_CLK2M = 4'hE;
  localparam logic [3:0] OFN_AUX_RST = 4'hF;

  // Filter lengths in clock cycles
  localparam int DEB_SHORT_CYC = 16;
  localparam int DEB_LONG_CYC = 1024;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== pfc_pin_chk.sv
/*
 * Port checker for the pin control block: bus handshakes, pull
 * enables and pad state after reset.
 * Assumes it is bound to pfc_pin_control and sees only its ports.
 */
`timescale 1ns/1ps
module pfc_pin_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pin_oe,
  input wire logic pull_up_en,
  input wire logic pull_down_en
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Bus transfer steps
  sequence aw_taken;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence both_taken;
    aw_taken ##0 (s_axi_wvalid && s_axi_wready);
  endsequence
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Pull enables never fight; pad quiet out of reset
  chk_pull_exclusive:
    assert property (!(pull_up_en && pull_down_en))
    else $error("both pull enables high");
  chk_reset_state:
    assert property ($rose(aresetn) |-> !pin_oe ##1 !pin_oe ##1
      (pull_down_en && !pull_up_en))
    else $error("pad state wrong after reset");
  // Bus refusals and answers
  chk_aw_refused:
    assert property (aw_taken |=> !s_axi_awready)
    else $error("write address ready after take");
  chk_ar_refused:
    assert property (ar_taken |=> !s_axi_arready)
    else $error("read address ready after take");
  chk_b_answer:
    assert property (both_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  chk_r_answer:
    assert property (ar_taken |=> s_axi_rvalid)
    else $error("read data late");
  chk_b_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_r_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule // pfc_pin_chk

bind pfc_pin_control pfc_pin_chk pfc_pin_chk_inst (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .pin_oe, .pull_up_en, .pull_down_en);

// ===== pfc_pad_model.sv
/*
 * Far-side pad model: resolves the wire from the block's drive, an
 * external driver and the pulls, and returns it as pin_in.
 * Assumes the bench drives ext_oe and ext_val on the clock edge.
 */
`timescale 1ns/1ps
module pfc_pad_model (
  input wire logic aclk,
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic pull_up_en,
  input wire logic pull_down_en,
  input wire logic ext_oe,
  input wire logic ext_val,
  output logic pin_in = 1'b0
);
  // Wire level; a pin nobody holds flips to its inverse each cycle
  always @(posedge aclk) begin
    if (pin_oe) begin
      pin_in <= pin_out;
    end else if (ext_oe) begin
      pin_in <= ext_val;
    end else if (pull_up_en || pull_down_en) begin
      pin_in <= pull_up_en;
    end else begin
      pin_in <= !pin_in;
    end
  end
endmodule // pfc_pad_model

// ===== test_pin3_function_control.sv
/*
 * Self-checking bench for the pin control block.
 * Assumes pfc_pkg, the pad model and the bound checker are compiled.
 */
`timescale 1ns/1ps
module test_pin3_function_control;
  localparam int SH = 2;
  localparam int LG = 40;
  logic aclk = 0, aresetn = 0, ext_oe = 0, ext_val = 0;
  logic [17:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv, r;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, pin_in, pin_out, pin_oe, pull_up_en, pull_down_en;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic io_supply_domain_select, irq, p, o, e, m, d;
  logic [15:0] src = 0;
  logic osc_32k_clk, on_state, sleep_state, power_state_change;
  logic dcdc1_scaling_done, dcdc2_scaling_done, ext_power_en1;
  logic ext_power_en2, system_supply_good, converter_power_good;
  logic ext_power_clk_2m, aux_reset, power_onoff_req, sleep_wake_req;
  logic sleep_wake_long_req, sleep_req, power_on_req, watchdog_reset_in;
  logic voltage_scaling_select_one, voltage_scaling_select_two;
  logic hw_enable1, hw_enable2, hw_control1, hw_control2;
  logic hw_control1_long, hw_control2_long;
  logic [13:0] rt;
  int n_errors = 0, num_checks = 0, cyc = 0, seed = 72906;

  // Output sources indexed by function code; routes from code 2 up
  assign {power_state_change, sleep_state, on_state, osc_32k_clk} = src[4:1];
  assign {aux_reset, ext_power_clk_2m, converter_power_good,
    system_supply_good, ext_power_en2, ext_power_en1, dcdc2_scaling_done,
    dcdc1_scaling_done} = src[15:8];
  assign rt = {hw_control2_long, hw_control1_long, hw_control2, hw_control1,
    hw_enable2, hw_enable1, voltage_scaling_select_two,
    voltage_scaling_select_one, watchdog_reset_in, power_on_req, sleep_req,
    sleep_wake_long_req, sleep_wake_req, power_onoff_req};

  pfc_pin_control #(.DEB_SHORT(SH), .DEB_LONG(LG)) pfc_pin_control_inst (.*);
  pfc_pad_model pfc_pad_model_inst (.*);

  // Clock and hang guard
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc > 10000) begin
      n_errors++;
      results;
    end
  end

  task automatic results;
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Expected pad enable and level for a polarised source level
  function automatic logic [1:0] pad_exp(input logic lvl, input logic od);
    return od ? {!lvl, 1'b0} : {1'b1, lvl};
  endfunction

  // Expected status: both edges, or only the logical rising edge
  function automatic logic edge_exp(input logic md, input logic pl,
      input logic dn);
    return md | (dn == pl);
  endfunction

  task automatic tk(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Bus write; response taken a cycle late on purpose
  task automatic wr(input logic [15:0] i, input logic [31:0] v,
      input logic [3:0] s);
    bit ga, gw;
    ga = 0;
    gw = 0;
    s_axi_awaddr <= {i, 2'h0};
    s_axi_awprot <= 3'($random(seed));
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (!(ga && gw)) begin
      @(posedge aclk);
      if (s_axi_awready) begin
        ga = 1;
        s_axi_awvalid <= 0;
      end
      if (s_axi_wready) begin
        gw = 1;
        s_axi_wvalid <= 0;
      end
    end
    tk(2);
    s_axi_bready <= 1;
    do @(posedge aclk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask

  // Bus read; data taken a cycle late on purpose
  task automatic rd(input logic [15:0] i);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arprot <= 3'($random(seed));
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    @(posedge aclk);
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 0;
  endtask

  task automatic ctl(input logic [31:0] v);
    wr(pfc_pkg::IDX_CONTROL, v, 4'h3);
  endtask

  // Main sequence
  initial begin
    tk(4);
    aresetn <= 1;
    tk(3);
    r = 32'({pin_oe, pull_up_en, pull_down_en, io_supply_domain_select});
    chk(r, 32'h2);
    rd(pfc_pkg::IDX_CONTROL);
    chk(rv, 32'hA400);
    rd(16'h0001);
    chk(rv, 32'h0);
    chk(32'(rsp), 32'(pfc_pkg::RESP_SLVERR));
    wr(16'h0002, 32'h1, 4'hF);
    chk(32'(rsp), 32'(pfc_pkg::RESP_SLVERR));
    ctl(32'hFFFFFFFF);
    rd(pfc_pkg::IDX_CONTROL);
    chk(rv, 32'hFE8F);
    chk(32'({pull_up_en, pull_down_en, io_supply_domain_select}), 1);
    ctl(32'hC000);
    chk(32'({pull_up_en, pull_down_en, io_supply_domain_select}), 4);
    ctl(32'h8000);
    chk(32'({pull_up_en, pull_down_en, io_supply_domain_select}), 0);
    wr(pfc_pkg::IDX_CONTROL, 32'hFFFF, 4'h1);
    rd(pfc_pkg::IDX_CONTROL);
    chk(rv, 32'h808F);
    // Every output code, random polarity, drive type and sources
    for (int c = 0; c < 16; c++) begin
      r = $random(seed);
      src <= r[15:0];
      p = r[16];
      o = r[17];
      wr(pfc_pkg::IDX_LEVEL, {31'h0, r[0]}, 4'h1);
      ctl(32'h80 | {p, o, 9'h0} | c);
      tk(2);
      e = (c inside {[5:7]}) ? 1'b0 : r[c];
      e = e ^ !p;
      chk(32'({pin_oe, pin_out}), 32'(pad_exp(e, o)));
    end
    ctl(32'h0001);
    chk(32'(pin_oe), 0);
    // Every input code, short and long filters
    ext_oe <= 1;
    for (int c = 0; c < 16; c++) begin
      r = $random(seed);
      p = r[0];
      ext_val <= !p;
      ctl(32'h8080 | {p, 10'h0} | c);
      tk(LG + 8);
      chk(32'(rt), 0);
      ext_val <= p;
      tk(SH + 8);
      e = c inside {0, 4, 14, 15};
      chk(32'(rt), (c < 2 || e) ? 0 : 1 << (c - 2));
      tk(LG);
      chk(32'(rt), c < 2 ? 0 : 1 << (c - 2));
      rd(pfc_pkg::IDX_LEVEL);
      if (c < 2) chk(32'(rv[1]), 1);
    end
    // Edge modes against polarity and edge direction
    wr(pfc_pkg::IDX_MASK, 32'h1, 4'h1);
    for (int k = 0; k < 8; k++) begin
      {m, p, d} = k[2:0];
      ext_val <= !d;
      ctl(32'h8081 | {m, 1'b0, p, 10'h0});
      tk(12);
      wr(pfc_pkg::IDX_STATUS, 32'h1, 4'h1);
      ext_val <= d;
      tk(12);
      e = edge_exp(m, p, d);
      rd(pfc_pkg::IDX_STATUS);
      chk(32'({irq, rv[0]}), 32'({e, e}));
    end
    wr(pfc_pkg::IDX_STATUS, 32'h1, 4'h1);
    tk(2);
    chk(32'(irq), 0);
    wr(pfc_pkg::IDX_MASK, 32'h0, 4'h1);
    ext_val <= 0;
    tk(12);
    rd(pfc_pkg::IDX_STATUS);
    chk(32'({irq, rv[0]}), 1);
    results;
  end
endmodule // test_pin3_function_control
